// *** rtl/eralic_pkg.sv ***
// shared constants and types for the receive alarm latch and irq block
package eralic_pkg;

  // ------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [9:0] IDX_CTRL     = 10'h120;
  localparam logic [9:0] IDX_STAT1    = 10'h124;
  localparam logic [9:0] IDX_STAT2    = 10'h126;
  localparam logic [9:0] IDX_LATCH1   = 10'h128;
  localparam logic [9:0] IDX_LATCH2   = 10'h12A;
  localparam logic [9:0] IDX_IE1      = 10'h12C;
  localparam logic [9:0] IDX_IE2      = 10'h12E;
  localparam logic [9:0] IDX_FE_COUNT = 10'h134;
  localparam logic [9:0] IDX_PORT_EN  = 10'h140;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int POS_UNFRAMED  = 8;
  localparam int POS_A_BIT     = 7;
  localparam int POS_N_BIT     = 6;
  localparam int POS_ALIGN     = 5;
  localparam int POS_FRAME_LOS = 4;
  localparam int POS_REMOTE    = 3;
  localparam int POS_ONES_AIS  = 2;
  localparam int POS_OOF       = 1;
  localparam int POS_SIG_LOSS  = 0;
  localparam int POS_FE_EVENT  = 8;
  localparam int POS_FE_NZ     = 0;
  localparam int POS_ECC       = 10;
  localparam int POS_SEL_LO    = 8;
  localparam int POS_PORT_EN   = 0;

  // ------------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------------
  localparam int LATCH1_W = 9;
  localparam int ALIGN_W  = 11;
  localparam int COUNT_W  = 16;
  localparam logic [3:0]  FAS_BIT_CAP   = 4'hA;
  localparam logic [8:0]  RST_IE1       = 9'h000;
  localparam logic [1:0]  RST_IE2       = 2'h0;
  localparam logic [1:0]  RST_SEL       = 2'h0;
  localparam logic [15:0] RST_COUNT     = 16'h0000;
  localparam logic [31:0] RST_RDATA     = 32'h00000000;

  // ------------------------------------------------------------------
  // modes and states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_OOF_OCCUR = 2'h0,
    SEL_FAS_BITS  = 2'h1,
    SEL_FAS_WORDS = 2'h2,
    SEL_RESERVED  = 2'h3
  } eralic_sel_t;

  typedef enum {BUS_IDLE, BUS_ACCESS} eralic_bus_t;

endpackage

// *** rtl/eralic_edge_latch.sv ***
// sticky change latches with write-one-to-clear
`timescale 1ns/100ps
`default_nettype none
module eralic_edge_latch
  import eralic_pkg::*;
#(
  parameter int          W         = 1,
  parameter logic [W-1:0] RISE_ONLY = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] levelIn,
  input  wire logic [W-1:0] extSet,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] latched
);

  typedef struct packed {
    logic         primed;
    logic [W-1:0] prev;
    logic [W-1:0] latch;
  } eralic_el_t;

  eralic_el_t stateReg;
  eralic_el_t stateNext;
  logic [W-1:0] setVec;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;
    setVec    = extSet;
    if (stateReg.primed) begin
      // rise-only bits ignore the falling edge
      setVec = setVec | (levelIn & ~stateReg.prev & RISE_ONLY)
             | ((levelIn ^ stateReg.prev) & ~RISE_ONLY);
    end
    stateNext.primed = 1'b1;
    stateNext.prev   = levelIn;
    // a new event wins over a clear in the same cycle
    stateNext.latch  = (stateReg.latch & ~clr) | setVec;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign latched = stateReg.latch;

endmodule
`default_nettype wire

// *** rtl/eralic_err_counter.sv ***
// framing error event counter with transfer on the monitor update
`timescale 1ns/100ps
`default_nettype none
module eralic_err_counter
  import eralic_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic [1:0]         countSel,
  input  wire logic               countAlways,
  input  wire logic               outOfFrame,
  input  wire logic               onesAlarm,
  input  wire logic               fasCheck,
  input  wire logic [3:0]         fasBitErrs,
  input  wire logic               perfMonitorUpdate,
  output logic      [COUNT_W-1:0] framingErrorTotal
);

  typedef struct packed {
    logic               prevOof;
    logic [COUNT_W-1:0] acc;
    logic [COUNT_W-1:0] total;
  } eralic_ec_t;

  eralic_ec_t         stateReg;
  eralic_ec_t         stateNext;
  logic [3:0]         inc;
  logic [3:0]         capped;
  logic               allowed;
  logic [COUNT_W:0]   sum;
  logic [COUNT_W-1:0] accInc;

  always_comb begin
    stateNext = stateReg;
    capped    = (fasBitErrs > FAS_BIT_CAP) ? FAS_BIT_CAP : fasBitErrs;
    allowed   = countAlways | ~(outOfFrame | onesAlarm);
    inc       = 4'h0;
    unique case (eralic_sel_t'(countSel))
      SEL_OOF_OCCUR: inc = {3'h0, outOfFrame & ~stateReg.prevOof};
      SEL_FAS_BITS:  inc = (fasCheck && allowed) ? capped : 4'h0;
      SEL_FAS_WORDS: inc = {3'h0, fasCheck & allowed & (fasBitErrs != 4'h0)};
      SEL_RESERVED:  inc = 4'h0;
    endcase
    sum    = {1'b0, stateReg.acc} + {{(COUNT_W - 3){1'b0}}, inc};
    accInc = sum[COUNT_W] ? {COUNT_W{1'b1}} : sum[COUNT_W-1:0];
    stateNext.prevOof = outOfFrame;
    if (perfMonitorUpdate) begin
      // visible count moves only on the update
      stateNext.total = accInc;
      stateNext.acc   = RST_COUNT;
    end else begin
      stateNext.acc = accInc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign framingErrorTotal = stateReg.total;

endmodule
`default_nettype wire

// *** rtl/eralic_top.sv ***
// receive alarm change latches, interrupt gating and error count access
//
// Functional notes
// - unframed-ones toggle sets latch bit 8
// - A-bit toggle sets latch bit 7
// - N-bit toggle sets latch bit 6
// - new differing alignment sets bit 5
// - frame-loss transition sets bit 4
// - remote-alarm transition sets bit 3
// - ones-alarm transition sets bit 2
// - out-of-frame transition sets bit 1
// - signal-loss transition sets bit 0
// - detected framing error sets second latch bit 8
// - count-nonzero rising edge sets bit 0
// - enable bit 8 gates unframed-ones irq
// - enable bit 7 gates A-bit irq
// - enable bit 6 gates N-bit irq
// - enable bit 5 gates alignment irq
// - enable bits 4..0 gate alarm latches
// - second enable bit 8 gates error event
// - second enable bit 0 gates count latch
// - port enable must be set for irq
// - sixteen-bit readable framing error count
// - count refreshed only on monitor update
// - two-bit select chooses counted event type
// - count control bit set keeps counting during alarms
// - nonzero flag shows count above zero
`timescale 1ns/100ps
`default_nettype none
module eralic_top
  import eralic_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic               hsel,
  input  wire logic [11:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               unframedOnesState,
  input  wire logic               receivedABit,
  input  wire logic               receivedNBit,
  input  wire logic               frameLossState,
  input  wire logic               remoteAlarmState,
  input  wire logic               onesAlarmState,
  input  wire logic               outOfFrameState,
  input  wire logic               signalLossState,
  input  wire logic               alignLoad,
  input  wire logic [ALIGN_W-1:0] alignValue,
  input  wire logic               fasCheck,
  input  wire logic [3:0]         fasBitErrs,
  input  wire logic               perfMonitorUpdate,
  output logic                    portIrq
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    eralic_bus_t        busState;
    logic [9:0]         accIdx;
    logic               accWrite;
    logic [31:0]        rdata;
    logic               readyOut;
    logic               countAlways;
    logic [1:0]         countSel;
    logic [8:0]         statusIrqEnable;
    logic               framingEventIrqEnable;
    logic               countNonzeroIrqEnable;
    logic               portStatusIrqEnable;
    logic               alignValid;
    logic [ALIGN_W-1:0] alignPrev;
    logic               irq;
  } eralic_top_t;

  eralic_top_t stateReg;
  eralic_top_t stateNext;

  logic [LATCH1_W-1:0] statusLevels;
  logic [LATCH1_W-1:0] statusExtSet;
  logic [LATCH1_W-1:0] statusClr;
  logic [LATCH1_W-1:0] statusChangeLatch;
  logic [LATCH1_W-1:0] statusHits;
  logic [1:0]          errLevels;
  logic [1:0]          errExtSet;
  logic [1:0]          errClr;
  logic [1:0]          errorEventLatch;
  logic [COUNT_W-1:0]  framingErrorTotal;
  logic                errorCountNonzero;
  logic                alignChange;
  logic                framingErrorSeen;
  logic                dataPhaseWrite;
  logic [15:0]         stat1Word;
  logic [15:0]         stat2Word;
  logic [15:0]         latch2Word;
  logic [15:0]         ie2Word;
  logic [15:0]         ctrlWord;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic addrPhase(input logic sel, input logic [1:0] trans,
                                     input logic rdy);
    addrPhase = sel && trans[1] && rdy;
  endfunction

  function automatic logic [15:0] placePair(input logic [1:0] pair);
    placePair = 16'h0000;
    placePair[POS_FE_EVENT] = pair[1];
    placePair[POS_FE_NZ]    = pair[0];
  endfunction

  // ------------------------------------------------------------------
  // event sources
  // ------------------------------------------------------------------
  // alignment change: only a load with a value unlike the held one
  assign alignChange = alignLoad && stateReg.alignValid
                     && (alignValue != stateReg.alignPrev);

  assign framingErrorSeen = fasCheck && (fasBitErrs != 4'h0);

  assign errorCountNonzero = (framingErrorTotal != RST_COUNT);

  always_comb begin
    statusLevels = '0;
    statusLevels[POS_UNFRAMED]  = unframedOnesState;
    statusLevels[POS_A_BIT]     = receivedABit;
    statusLevels[POS_N_BIT]     = receivedNBit;
    statusLevels[POS_FRAME_LOS] = frameLossState;
    statusLevels[POS_REMOTE]    = remoteAlarmState;
    statusLevels[POS_ONES_AIS]  = onesAlarmState;
    statusLevels[POS_OOF]       = outOfFrameState;
    statusLevels[POS_SIG_LOSS]  = signalLossState;
    statusExtSet = '0;
    statusExtSet[POS_ALIGN] = alignChange;
  end

  assign errLevels = {1'b0, errorCountNonzero};
  assign errExtSet = {framingErrorSeen, 1'b0};

  // ------------------------------------------------------------------
  // interrupt sources
  // ------------------------------------------------------------------
  // status change latches masked by their own enables
  assign statusHits = statusChangeLatch & stateReg.statusIrqEnable;

  // ------------------------------------------------------------------
  // write-one-to-clear strobes, data phase only
  // ------------------------------------------------------------------
  assign dataPhaseWrite = (stateReg.busState == BUS_ACCESS) && stateReg.accWrite;

  always_comb begin
    statusClr = '0;
    errClr    = '0;
    if (dataPhaseWrite && stateReg.accIdx == IDX_LATCH1) begin
      statusClr = hwdata[LATCH1_W-1:0];
    end
    if (dataPhaseWrite && stateReg.accIdx == IDX_LATCH2) begin
      errClr = {hwdata[POS_FE_EVENT], hwdata[POS_FE_NZ]};
    end
  end

  // ------------------------------------------------------------------
  // latches and counter
  // ------------------------------------------------------------------
  eralic_edge_latch #(
    .W         (LATCH1_W),
    .RISE_ONLY ('0)
  ) uStatusLatch (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .levelIn (statusLevels),
    .extSet  (statusExtSet),
    .clr     (statusClr),
    .latched (statusChangeLatch)
  );

  // only the count-nonzero bit is edge sensitive, rising only
  eralic_edge_latch #(
    .W         (2),
    .RISE_ONLY (2'h1)
  ) uErrorLatch (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .levelIn (errLevels),
    .extSet  (errExtSet),
    .clr     (errClr),
    .latched (errorEventLatch)
  );

  eralic_err_counter uCounter (
    .ref_clk           (ref_clk),
    .rst_b             (rst_b),
    .countSel          (stateReg.countSel),
    .countAlways       (stateReg.countAlways),
    .outOfFrame        (outOfFrameState),
    .onesAlarm         (onesAlarmState),
    .fasCheck          (fasCheck),
    .fasBitErrs        (fasBitErrs),
    .perfMonitorUpdate (perfMonitorUpdate),
    .framingErrorTotal (framingErrorTotal)
  );

  // ------------------------------------------------------------------
  // readback words
  // ------------------------------------------------------------------
  always_comb begin
    // reserved bits read back as zero
    stat1Word = {7'h00, statusLevels};
    stat1Word[POS_ALIGN] = 1'b0;
    stat2Word = {15'h0000, errorCountNonzero};
    latch2Word = placePair(errorEventLatch);
    ie2Word = placePair({stateReg.framingEventIrqEnable,
                         stateReg.countNonzeroIrqEnable});
    ctrlWord = 16'h0000;
    ctrlWord[POS_ECC] = stateReg.countAlways;
    ctrlWord[POS_SEL_LO+1 -: 2] = stateReg.countSel;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;

    // alignment reference follows every load
    if (alignLoad) begin
      stateNext.alignValid = 1'b1;
      stateNext.alignPrev  = alignValue;
    end

    // bus: address phase, then one wait cycle that acts and loads data
    unique case (stateReg.busState)
      BUS_IDLE: begin
        stateNext.readyOut = 1'b1;
        if (addrPhase(hsel, htrans, hready)) begin
          stateNext.busState = BUS_ACCESS;
          stateNext.accIdx   = haddr[11:2];
          stateNext.accWrite = hwrite;
          stateNext.readyOut = 1'b0;
        end
      end
      BUS_ACCESS: begin
        stateNext.readyOut = 1'b1;
        stateNext.busState = BUS_IDLE;
        stateNext.rdata    = RST_RDATA;
        if (stateReg.accWrite) begin
          unique case (stateReg.accIdx)
            IDX_CTRL: begin
              stateNext.countAlways = hwdata[POS_ECC];
              stateNext.countSel    = hwdata[POS_SEL_LO+1 -: 2];
            end
            IDX_IE1: begin
              stateNext.statusIrqEnable = hwdata[LATCH1_W-1:0];
            end
            IDX_IE2: begin
              stateNext.framingEventIrqEnable = hwdata[POS_FE_EVENT];
              stateNext.countNonzeroIrqEnable = hwdata[POS_FE_NZ];
            end
            IDX_PORT_EN: begin
              stateNext.portStatusIrqEnable = hwdata[POS_PORT_EN];
            end
            default: begin
              stateNext.rdata = RST_RDATA;
            end
          endcase
        end else begin
          unique case (stateReg.accIdx)
            IDX_CTRL:     stateNext.rdata = {16'h0000, ctrlWord};
            IDX_STAT1:    stateNext.rdata = {16'h0000, stat1Word};
            IDX_STAT2:    stateNext.rdata = {16'h0000, stat2Word};
            IDX_LATCH1:   stateNext.rdata = {23'h000000, statusChangeLatch};
            IDX_LATCH2:   stateNext.rdata = {16'h0000, latch2Word};
            IDX_IE1:      stateNext.rdata = {23'h000000, stateReg.statusIrqEnable};
            IDX_IE2:      stateNext.rdata = {16'h0000, ie2Word};
            IDX_FE_COUNT: stateNext.rdata = {16'h0000, framingErrorTotal};
            IDX_PORT_EN:  stateNext.rdata = {31'h00000000,
                                             stateReg.portStatusIrqEnable};
            default:      stateNext.rdata = RST_RDATA;
          endcase
        end
      end
    endcase

    // interrupt: any enabled latch, then the port gate
    // a level: drops once the latch or its enable clears
    stateNext.irq = stateReg.portStatusIrqEnable
      && (statusHits[POS_UNFRAMED]
          || statusHits[POS_A_BIT]
          || statusHits[POS_N_BIT]
          || statusHits[POS_ALIGN]
          || statusHits[POS_FRAME_LOS]
          || statusHits[POS_REMOTE]
          || statusHits[POS_ONES_AIS]
          || statusHits[POS_OOF]
          || statusHits[POS_SIG_LOSS]
          || (errorEventLatch[1] && stateReg.framingEventIrqEnable)
          || (errorEventLatch[0] && stateReg.countNonzeroIrqEnable));
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stateReg.busState              <= BUS_IDLE;
      stateReg.accIdx                <= 10'h000;
      stateReg.accWrite              <= 1'b0;
      stateReg.rdata                 <= RST_RDATA;
      stateReg.readyOut              <= 1'b1;
      stateReg.countAlways           <= 1'b0;
      stateReg.countSel              <= RST_SEL;
      stateReg.statusIrqEnable       <= RST_IE1;
      stateReg.framingEventIrqEnable <= RST_IE2[1];
      stateReg.countNonzeroIrqEnable <= RST_IE2[0];
      stateReg.portStatusIrqEnable   <= 1'b0;
      stateReg.alignValid            <= 1'b0;
      stateReg.alignPrev             <= '0;
      stateReg.irq                   <= 1'b0;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign hrdata    = stateReg.rdata;
  assign hreadyout = stateReg.readyOut;
  // transfers always complete without error
  assign hresp     = 1'b0;
  assign portIrq   = stateReg.irq;

endmodule
`default_nettype wire

// *** tb/eralic_asserts.sv ***
// port-level assertions for the alarm latch block
`timescale 1ns/100ps
`default_nettype none
module eralic_asserts
  import eralic_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        unframedOnesState,
  input wire logic        receivedABit,
  input wire logic        receivedNBit,
  input wire logic        frameLossState,
  input wire logic        remoteAlarmState,
  input wire logic        onesAlarmState,
  input wire logic        outOfFrameState,
  input wire logic        signalLossState,
  input wire logic        fasCheck,
  input wire logic [3:0]  fasBitErrs,
  input wire logic        portIrq
);
  // ----
  // shadow of the enable registers, snooped from the bus
  // ----
  logic [9:0] aIdx;
  logic       aWr;
  logic       pend;
  logic       enSh;
  logic [8:0] ie1Sh;
  logic [1:0] ie2Sh;
  logic [8:0] lvl;
  assign lvl = {unframedOnesState, receivedABit, receivedNBit, 1'b0, frameLossState,
                remoteAlarmState, onesAlarmState, outOfFrameState, signalLossState};
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      aIdx  <= 10'h000;
      aWr   <= 1'b0;
      pend  <= 1'b0;
      enSh  <= 1'b0;
      ie1Sh <= 9'h000;
      ie2Sh <= 2'h0;
    end else begin
      if (hsel && htrans[1] && hready) begin
        aIdx <= haddr[11:2];
        aWr  <= hwrite;
      end
      pend <= hsel && htrans[1] && hready;
      if (pend && aWr && aIdx == IDX_IE1) ie1Sh <= hwdata[8:0];
      if (pend && aWr && aIdx == IDX_IE2) ie2Sh <= {hwdata[8], hwdata[0]};
      if (pend && aWr && aIdx == IDX_PORT_EN) enSh <= hwdata[0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  xfer_wait_a: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("data phase not one wait cycle");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  port_gate_a: assert property (portIrq |-> $past(enSh))
    else $error("irq without port enable");
  port_off_a: assert property ($fell(enSh) |=> !portIrq)
    else $error("irq stays after port disable");
  irq_source_a: assert property (
    portIrq |-> $past(ie1Sh) != 9'h000 || $past(ie2Sh) != 2'h0)
    else $error("irq with no enable set");
  level_irq_a: assert property (
    enSh && ((lvl ^ $past(lvl)) & ie1Sh) != 9'h000 |-> ##[1:3] portIrq)
    else $error("enabled level change gave no irq");
  fe_irq_a: assert property (
    enSh && ie2Sh[1] && fasCheck && fasBitErrs != 4'h0 |-> ##[1:3] portIrq)
    else $error("framing error gave no irq");
  ie1_read_a: assert property (
    $rose(hreadyout) && !aWr && aIdx == IDX_IE1 |-> hrdata == {23'h0, ie1Sh})
    else $error("enable register read mismatch");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_b |=> !portIrq && hreadyout)
    else $error("outputs not idle in reset");
endmodule
bind eralic_top eralic_asserts eralic_asserts_i (.ref_clk, .rst_b, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .unframedOnesState, .receivedABit,
  .receivedNBit, .frameLossState, .remoteAlarmState, .onesAlarmState, .outOfFrameState,
  .signalLossState, .fasCheck, .fasBitErrs, .portIrq);
`default_nettype wire

// *** tb/eralic_top_tb.sv ***
// self-checking bench for the alarm latch block
`timescale 1ns/100ps
`default_nettype none
module eralic_top_tb;
  import eralic_pkg::*;
  logic        ref_clk, rst_b, hsel, hwrite, hreadyout, hresp, portIrq;
  logic        fasCheck, perf_monitor_update, alignLoad;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd, m;
  logic [8:0]  lvl;
  logic [10:0] alignValue;
  logic [3:0]  fasBitErrs;
  int          err_count, tests_run, cyc;
  int          bitPos [8] = '{8, 7, 6, 4, 3, 2, 1, 0};
  logic [9:0]  regIdx [5] = '{IDX_IE1, IDX_IE2, IDX_LATCH1, IDX_LATCH2, IDX_FE_COUNT};
  eralic_top eralic_top_i (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .unframedOnesState(lvl[8]),
    .receivedABit(lvl[7]), .receivedNBit(lvl[6]), .frameLossState(lvl[4]),
    .remoteAlarmState(lvl[3]), .onesAlarmState(lvl[2]), .outOfFrameState(lvl[1]),
    .signalLossState(lvl[0]), .alignLoad(alignLoad), .alignValue(alignValue),
    .fasCheck(fasCheck), .fasBitErrs(fasBitErrs), .perfMonitorUpdate(perf_monitor_update),
    .portIrq(portIrq));
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  // ----
  // bus and stimulus tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {idx, 2'h0};
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask
  // kind bits: align load, monitor update, alignment check
  task automatic pulse(input logic [2:0] k, input logic [10:0] v);
    {alignLoad, perf_monitor_update, fasCheck} <= k;
    alignValue <= v;
    fasBitErrs <= v[3:0];
    @(posedge ref_clk);
    {alignLoad, perf_monitor_update, fasCheck} <= 3'h0;
    tick(3);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 12'h000;
    hwrite = 1'b0;
    hwdata = 32'h0;
    lvl = 9'h000;
    {alignLoad, perf_monitor_update, fasCheck} = 3'h0;
    alignValue = 11'h000;
    fasBitErrs = 4'h0;
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    tick(8);
    rst_b <= 1'b1;
    tick(2);
    foreach (regIdx[i]) rchk(regIdx[i], 32'h0);
    bus(1'b1, IDX_IE1, 32'hFFFF);
    rchk(IDX_IE1, 32'h1FF);
    bus(1'b1, IDX_IE2, 32'hFFFF);
    rchk(IDX_IE2, 32'h101);
    bus(1'b1, IDX_FE_COUNT, 32'h1234);
    rchk(IDX_FE_COUNT, 32'h0);
    bus(1'b1, 10'h130, 32'hFFFF);
    rchk(10'h130, 32'h0);
    bus(1'b1, IDX_CTRL, 32'h100);
    rchk(IDX_CTRL, 32'h100);
    pulse(3'h1, 11'h00C);
    rchk(IDX_FE_COUNT, 32'h0);
    rchk(IDX_LATCH2, 32'h100);
    check({31'h0, portIrq}, 32'h0);
    pulse(3'h2, 11'h000);
    rchk(IDX_FE_COUNT, 32'hA);
    rchk(IDX_STAT2, 32'h1);
    rchk(IDX_LATCH2, 32'h101);
    bus(1'b1, IDX_PORT_EN, 32'h1);
    tick(2);
    check({31'h0, portIrq}, 32'h1);
    bus(1'b1, IDX_IE2, 32'h100);
    bus(1'b1, IDX_LATCH2, 32'h100);
    tick(2);
    check({31'h0, portIrq}, 32'h0);
    bus(1'b1, IDX_IE2, 32'h001);
    tick(2);
    check({31'h0, portIrq}, 32'h1);
    bus(1'b1, IDX_LATCH2, 32'h001);
    rchk(IDX_LATCH2, 32'h0);
    bus(1'b1, IDX_CTRL, 32'h200);
    lvl[1] <= 1'b1;
    pulse(3'h1, 11'h003);
    bus(1'b1, IDX_CTRL, 32'h600);
    pulse(3'h1, 11'h003);
    bus(1'b1, IDX_CTRL, 32'h700);
    pulse(3'h1, 11'h003);
    bus(1'b1, IDX_CTRL, 32'h000);
    lvl[1] <= 1'b0;
    tick(2);
    lvl[1] <= 1'b1;
    tick(2);
    pulse(3'h2, 11'h000);
    rchk(IDX_FE_COUNT, 32'h2);
    rchk(IDX_LATCH2, 32'h100);
    pulse(3'h2, 11'h000);
    rchk(IDX_FE_COUNT, 32'h0);
    rchk(IDX_STAT2, 32'h0);
    rchk(IDX_LATCH2, 32'h100);
    lvl <= 9'h000;
    bus(1'b1, IDX_IE2, 32'h0);
    bus(1'b1, IDX_LATCH2, 32'h1FF);
    bus(1'b1, IDX_LATCH1, 32'h1FF);
    rchk(IDX_LATCH1, 32'h0);
    foreach (bitPos[k]) begin
      m = 32'h1 << bitPos[k];
      lvl[bitPos[k]] <= 1'b1;
      tick(3);
      rchk(IDX_LATCH1, m);
      bus(1'b1, IDX_IE1, ~m & 32'h1FF);
      tick(2);
      check({31'h0, portIrq}, 32'h0);
      bus(1'b1, IDX_IE1, m);
      tick(2);
      check({31'h0, portIrq}, 32'h1);
      bus(1'b1, IDX_LATCH1, m);
      rchk(IDX_LATCH1, 32'h0);
      lvl[bitPos[k]] <= 1'b0;
      tick(3);
      rchk(IDX_LATCH1, m);
      bus(1'b1, IDX_LATCH1, m);
    end
    bus(1'b1, IDX_IE1, 32'h020);
    pulse(3'h4, 11'h123);
    pulse(3'h4, 11'h123);
    rchk(IDX_LATCH1, 32'h0);
    pulse(3'h4, 11'h456);
    rchk(IDX_LATCH1, 32'h20);
    check({31'h0, portIrq}, 32'h1);
    bus(1'b1, IDX_LATCH1, 32'h020);
    bus(1'b1, IDX_IE2, 32'h100);
    check({31'h0, portIrq}, 32'h0);
    pulse(3'h1, 11'h001);
    check({31'h0, portIrq}, 32'h1);
    bus(1'b1, IDX_PORT_EN, 32'h0);
    tick(2);
    check({31'h0, portIrq}, 32'h0);
    results();
  end
endmodule
`default_nettype wire
